// [rtl/rfo_defines.svh]
// constants for the rotate and fill datapath slice
// Behaviour
// (RQ1) rotate_left_plain moves bit 7 into bit 0; carry_flag not involved.
// (RQ2) rotate_left_plain updates negative_flag and zero_flag only; carry_flag kept.
// (RQ3) rotate_right_carry: old bit 0 to carry_flag, old carry_flag to bit 7.
// (RQ4) rotate_right_plain moves bit 0 into bit 7; updates negative and zero only.
// (RQ5) fill_ones_instr writes FFh to file register; no dest bit; flags untouched.
// (RQ6) rotates: dest bit 0 writes working_reg, dest bit 1 writes file register.
// (RQ7) access bit 0 uses access bank; access bit 1 uses bank_select_reg.
// (RQ8) rotate_left_carry: old bit 7 to carry_flag, old carry_flag to bit 0.
// (RQ9) negative_flag is result bit 7; zero_flag set when result is zero.
`ifndef RFO_DEFINES_SVH
`define RFO_DEFINES_SVH
// ==========================================
// instruction fields
`define RFO_OPC_HI 15
`define RFO_OPC_LO 10
`define RFO_FILL_LO 9
`define RFO_DEST_BIT 9
`define RFO_ACC_BIT 8
`define RFO_F_HI 7
`define RFO_OPC_RLP 6'h11
`define RFO_OPC_RLC 6'h0D
`define RFO_OPC_RRC 6'h0C
`define RFO_OPC_RRP 6'h10
`define RFO_OPC_FILL 7'h34
`define RFO_FILL_VAL 8'hFF
// ==========================================
// access bank split
`define RFO_ACC_SPLIT_BIT 7
`define RFO_ACC_LO_BANK 4'h0
`define RFO_ACC_HI_BANK 4'hF
// ==========================================
// register map, byte addresses
`define RFO_REG_WORKING_REG 4'h0
`define RFO_REG_BANK 4'h4
`define RFO_REG_STAT 4'h8
`define RFO_REG_LAST 4'hC
`define RFO_STAT_C 0
`define RFO_STAT_Z 2
`define RFO_STAT_N 4
`define RFO_LAST_BUSY 8
`define RFO_RST_BYTE 8'h00
`define RFO_RST_BANK 4'h0
`endif

// [rtl/rfo_pkg.sv]
// types for the rotate and fill datapath slice
package rfo_pkg;
    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_RLP = 3'h1,
        OP_RLC = 3'h2,
        OP_RRC = 3'h3,
        OP_RRP = 3'h4,
        OP_FILL = 3'h5
    } rfo_op_type;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_READ = 2'h1,
        ST_EXEC = 2'h2,
        ST_WB = 2'h3
    } rfo_state_type;
endpackage

// [rtl/rfo_alu.sv]
// combinational rotate and fill unit with flag results
`timescale 1ns/100ps
`include "rfo_defines.svh"
module rfo_alu (
    input wire rfo_pkg::rfo_op_type op,
    input wire logic [7:0] opnd,
    input wire logic c_in,
    output logic [7:0] res,
    output logic c_out,
    output logic n_out,
    output logic z_out
);
    always_comb begin
        res = opnd;
        c_out = c_in;
        unique case (op)
            rfo_pkg::OP_RLP: res = {opnd[6:0], opnd[7]}; // RQ1 RQ2
            rfo_pkg::OP_RLC: begin
                res = {opnd[6:0], c_in}; // RQ8
                c_out = opnd[7]; // RQ8
            end
            rfo_pkg::OP_RRC: begin
                res = {c_in, opnd[7:1]}; // RQ3
                c_out = opnd[0]; // RQ3
            end
            rfo_pkg::OP_RRP: res = {opnd[0], opnd[7:1]}; // RQ4
            rfo_pkg::OP_FILL: res = `RFO_FILL_VAL; // RQ5
            rfo_pkg::OP_NONE: res = opnd;
        endcase
        n_out = res[7]; // RQ9
        z_out = (res == 8'h00); // RQ9
    end
endmodule

// [rtl/rfo_bank.sv]
// file address former: access bank or banked by bank_select_reg
`timescale 1ns/100ps
`include "rfo_defines.svh"
module rfo_bank (
    input wire logic acc_sel,
    input wire logic [3:0] bank_sel,
    input wire logic [7:0] f_addr,
    output logic [11:0] full_addr
);
    logic [3:0] acc_bank;
    // low half of the access bank is bank 0, upper half the top bank
    assign acc_bank = f_addr[`RFO_ACC_SPLIT_BIT] ? `RFO_ACC_HI_BANK : `RFO_ACC_LO_BANK;
    assign full_addr = {acc_sel ? bank_sel : acc_bank, f_addr}; // RQ7
endmodule

// [rtl/rfo_top.sv]
// rotate and fill datapath slice with AHB-Lite register access
//
// Implementation choices: the AHB-Lite slave port and the address map.
`timescale 1ns/100ps
`include "rfo_defines.svh"
module rfo_top (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic [15:0] INSTR,
    input wire logic INSTR_VALID,
    output logic INSTR_READY,
    output logic [11:0] FILE_ADDR,
    output logic FILE_RE,
    input wire logic [7:0] FILE_RDATA,
    output logic FILE_WE,
    output logic [7:0] FILE_WDATA,
    output logic DONE
);
    // ==========================================
    // instruction decode
    rfo_pkg::rfo_state_type state_q;
    rfo_pkg::rfo_op_type dec_op;
    rfo_pkg::rfo_op_type op_q;
    logic dec_dest;
    logic take;
    logic dest_q;
    logic [7:0] opnd_q;
    logic [7:0] working_reg_q;
    logic [3:0] bank_q;
    logic c_q;
    logic z_q;
    logic n_q;
    logic [7:0] last_q;
    logic [11:0] addr_d;
    logic [7:0] res;
    logic c_new;
    logic n_new;
    logic z_new;
    logic to_file;

    always_comb begin
        dec_op = rfo_pkg::OP_NONE;
        unique case (INSTR[`RFO_OPC_HI:`RFO_OPC_LO])
            `RFO_OPC_RLP: dec_op = rfo_pkg::OP_RLP;
            `RFO_OPC_RLC: dec_op = rfo_pkg::OP_RLC;
            `RFO_OPC_RRC: dec_op = rfo_pkg::OP_RRC;
            `RFO_OPC_RRP: dec_op = rfo_pkg::OP_RRP;
            default: dec_op = rfo_pkg::OP_NONE;
        endcase
        if (INSTR[`RFO_OPC_HI:`RFO_FILL_LO] == `RFO_OPC_FILL) begin
            dec_op = rfo_pkg::OP_FILL;
        end
    end

    // fill has no destination bit: bit 9 is opcode there
    assign dec_dest = (dec_op == rfo_pkg::OP_FILL) ? 1'b1 : INSTR[`RFO_DEST_BIT]; // RQ5
    assign INSTR_READY = (state_q == rfo_pkg::ST_IDLE);
    // foreign opcodes are never taken, so the sequencer stays idle and ready
    assign take = INSTR_VALID && INSTR_READY && (dec_op != rfo_pkg::OP_NONE);

    rfo_bank u_bank (
        .acc_sel(INSTR[`RFO_ACC_BIT]),
        .bank_sel(bank_q),
        .f_addr(INSTR[`RFO_F_HI:0]),
        .full_addr(addr_d)
    );

    rfo_alu u_alu (
        .op(op_q),
        .opnd(opnd_q),
        .c_in(c_q),
        .res(res),
        .c_out(c_new),
        .n_out(n_new),
        .z_out(z_new)
    );

    // ==========================================
    // sequencer: decode, read f, process, write
    always_ff @(posedge MCLK) begin
        if (RST) begin
            state_q <= rfo_pkg::ST_IDLE;
        end else begin
            unique case (state_q)
                rfo_pkg::ST_IDLE: if (take) state_q <= rfo_pkg::ST_READ;
                rfo_pkg::ST_READ: state_q <= rfo_pkg::ST_EXEC;
                rfo_pkg::ST_EXEC: state_q <= rfo_pkg::ST_WB;
                rfo_pkg::ST_WB: state_q <= rfo_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            op_q <= rfo_pkg::OP_NONE;
            dest_q <= 1'b1;
            FILE_ADDR <= 12'h000;
        end else if (take) begin
            op_q <= dec_op;
            dest_q <= dec_dest;
            FILE_ADDR <= addr_d; // RQ7
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            FILE_RE <= 1'b0;
        end else begin
            FILE_RE <= take;
        end
    end

    // memory answers in the cycle the read strobe stands
    always_ff @(posedge MCLK) begin
        if (RST) begin
            opnd_q <= `RFO_RST_BYTE;
        end else if (state_q == rfo_pkg::ST_READ) begin
            opnd_q <= FILE_RDATA;
        end
    end

    assign to_file = (state_q == rfo_pkg::ST_EXEC) && dest_q;

    always_ff @(posedge MCLK) begin
        if (RST) begin
            FILE_WE <= 1'b0;
            FILE_WDATA <= `RFO_RST_BYTE;
        end else begin
            FILE_WE <= to_file; // RQ6
            if (to_file) begin
                FILE_WDATA <= res;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            DONE <= 1'b0;
            last_q <= `RFO_RST_BYTE;
        end else begin
            DONE <= (state_q == rfo_pkg::ST_EXEC);
            if (state_q == rfo_pkg::ST_EXEC) begin
                last_q <= res;
            end
        end
    end

    // ==========================================
    // AHB-Lite slave, zero wait states
    logic wr_pend_q;
    logic [3:0] wr_addr_q;
    logic rd_sel;
    logic [3:0] rd_addr;
    logic [31:0] rd_word;
    logic [31:0] rd_mux;
    logic exec_now;

    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign rd_sel = HSEL && HTRANS[1] && HREADY && !HWRITE;
    assign rd_addr = HADDR[3:0];
    assign exec_now = (state_q == rfo_pkg::ST_EXEC);

    always_ff @(posedge MCLK) begin
        if (RST) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 4'h0;
        end else if (HREADY) begin
            wr_pend_q <= HSEL && HTRANS[1] && HWRITE;
            wr_addr_q <= HADDR[3:0];
        end
    end

    // core writeback outranks a software write in the same cycle
    always_ff @(posedge MCLK) begin
        if (RST) begin
            working_reg_q <= `RFO_RST_BYTE;
        end else if (exec_now && !dest_q) begin
            working_reg_q <= res; // RQ6
        end else if (wr_pend_q && wr_addr_q == `RFO_REG_WORKING_REG) begin
            working_reg_q <= HWDATA[7:0];
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            bank_q <= `RFO_RST_BANK;
        end else if (wr_pend_q && wr_addr_q == `RFO_REG_BANK) begin
            bank_q <= HWDATA[3:0];
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            c_q <= 1'b0;
            z_q <= 1'b0;
            n_q <= 1'b0;
        end else if (exec_now && op_q != rfo_pkg::OP_FILL) begin
            c_q <= c_new; // RQ2 RQ3 RQ8
            z_q <= z_new; // RQ9
            n_q <= n_new; // RQ9
        end else if (wr_pend_q && wr_addr_q == `RFO_REG_STAT) begin
            c_q <= HWDATA[`RFO_STAT_C];
            z_q <= HWDATA[`RFO_STAT_Z];
            n_q <= HWDATA[`RFO_STAT_N];
        end
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (rd_addr)
            `RFO_REG_WORKING_REG: rd_word[7:0] = working_reg_q;
            `RFO_REG_BANK: rd_word[3:0] = bank_q;
            `RFO_REG_STAT: begin
                rd_word[`RFO_STAT_C] = c_q;
                rd_word[`RFO_STAT_Z] = z_q;
                rd_word[`RFO_STAT_N] = n_q;
            end
            `RFO_REG_LAST: begin
                rd_word[7:0] = last_q;
                rd_word[`RFO_LAST_BUSY] = !INSTR_READY;
            end
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // a read right behind a write to the same word sees the new data
    always_comb begin
        rd_mux = rd_word;
        if (wr_pend_q && wr_addr_q == rd_addr && rd_addr != `RFO_REG_LAST) begin
            rd_mux = HWDATA & rd_word_mask(rd_addr);
        end
    end

    function automatic logic [31:0] rd_word_mask(input logic [3:0] a);
        logic [31:0] m;
        m = 32'h0000_0000;
        unique case (a)
            `RFO_REG_WORKING_REG: m = 32'h0000_00FF;
            `RFO_REG_BANK: m = 32'h0000_000F;
            `RFO_REG_STAT: m = 32'h0000_0015;
            default: m = 32'h0000_0000;
        endcase
        return m;
    endfunction

    always_ff @(posedge MCLK) begin
        if (RST) begin
            HRDATA <= 32'h0000_0000;
        end else if (rd_sel) begin
            HRDATA <= rd_mux;
        end
    end

    // ==========================================
    // checks
    sequence s_exec_op(logic [2:0] o);
        state_q == rfo_pkg::ST_EXEC && op_q == o;
    endsequence

    a_rlp_result: assert property (@(posedge MCLK) disable iff (RST) // RQ1
        s_exec_op(rfo_pkg::OP_RLP) |=> last_q == {$past(opnd_q[6:0]), $past(opnd_q[7])})
        else $error("plain left rotate result wrong");

    a_rlp_carry: assert property (@(posedge MCLK) disable iff (RST) // RQ2
        s_exec_op(rfo_pkg::OP_RLP) |=> c_q == $past(c_q))
        else $error("plain left rotate changed carry");

    a_rrc_result: assert property (@(posedge MCLK) disable iff (RST) // RQ3
        s_exec_op(rfo_pkg::OP_RRC) |=> c_q == $past(opnd_q[0]) && last_q[7] == $past(c_q))
        else $error("right rotate through carry wrong");

    a_rrp_result: assert property (@(posedge MCLK) disable iff (RST) // RQ4
        s_exec_op(rfo_pkg::OP_RRP) |=> last_q == {$past(opnd_q[0]), $past(opnd_q[7:1])} && c_q == $past(c_q))
        else $error("plain right rotate wrong");

    a_fill_write: assert property (@(posedge MCLK) disable iff (RST) // RQ5
        s_exec_op(rfo_pkg::OP_FILL) |=> FILE_WE && FILE_WDATA == `RFO_FILL_VAL
            && {c_q, z_q, n_q} == $past({c_q, z_q, n_q}))
        else $error("fill did not write ones or touched flags");

    a_dest_working_reg: assert property (@(posedge MCLK) disable iff (RST) // RQ6
        state_q == rfo_pkg::ST_EXEC && !dest_q |=> !FILE_WE && working_reg_q == last_q)
        else $error("result not sent to working register");

    a_bank_addr: assert property (@(posedge MCLK) disable iff (RST) // RQ7
        take |=> FILE_ADDR[11:8] == ($past(INSTR[`RFO_ACC_BIT]) ? $past(bank_q)
            : ($past(INSTR[`RFO_ACC_SPLIT_BIT]) ? `RFO_ACC_HI_BANK : `RFO_ACC_LO_BANK)))
        else $error("file address bank wrong");

    a_rlc_result: assert property (@(posedge MCLK) disable iff (RST) // RQ8
        s_exec_op(rfo_pkg::OP_RLC) |=> c_q == $past(opnd_q[7]) && last_q == {$past(opnd_q[6:0]), $past(c_q)})
        else $error("left rotate through carry wrong");

    a_nz_flags: assert property (@(posedge MCLK) disable iff (RST) // RQ9
        state_q == rfo_pkg::ST_EXEC && op_q != rfo_pkg::OP_FILL |=> n_q == last_q[7] && z_q == (last_q == 8'h00))
        else $error("negative or zero flag wrong");

    a_seq_len: assert property (@(posedge MCLK) disable iff (RST) // RQ6
        take |=> FILE_RE ##1 !FILE_RE ##1 DONE)
        else $error("instruction sequence timing wrong");
endmodule

// [bench/rfo_mem.sv]
// data memory model standing on the far side of the file port
`timescale 1ns/100ps
module rfo_mem (
    input wire logic clk,
    input wire logic [11:0] addr,
    input wire logic re,
    input wire logic we,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] mem [0:4095];
    // ==========================================
    // read answers in the cycle the strobe stands, since the slice samples it there
    // outside a read the line shows the inverse, so a misplaced sample shows up
    assign rdata = re ? mem[addr] : ~mem[addr];
    always @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end
endmodule

// [bench/test_rotate_and_fill_ops.sv]
// self-checking bench for the rotate and fill datapath slice
`timescale 1ns/100ps
`include "rfo_defines.svh"
`define RFO_CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module test_rotate_and_fill_ops;
    logic MCLK = 1'b0;
    logic RST = 1'b1;
    logic HSEL = 1'b0;
    logic [31:0] HADDR = 32'h0;
    logic [1:0] HTRANS = 2'h0;
    logic HWRITE = 1'b0;
    logic [2:0] HSIZE = 3'h2;
    logic [31:0] HWDATA = 32'h0;
    logic [31:0] HRDATA;
    logic HREADYOUT, HRESP, INSTR_READY, FILE_RE, FILE_WE, DONE;
    logic [15:0] INSTR = 16'h0;
    logic INSTR_VALID = 1'b0;
    logic [11:0] FILE_ADDR;
    logic [7:0] FILE_RDATA, FILE_WDATA;
    logic [5:0] opc [4] = '{`RFO_OPC_RLP, `RFO_OPC_RLC, `RFO_OPC_RRC, `RFO_OPC_RRP};
    int error_cnt = 0;
    int samples_checked = 0;
    int cycles = 0;

    rfo_top i_dut (.MCLK(MCLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
        .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
        .HRESP(HRESP), .INSTR(INSTR), .INSTR_VALID(INSTR_VALID), .INSTR_READY(INSTR_READY),
        .FILE_ADDR(FILE_ADDR), .FILE_RE(FILE_RE), .FILE_RDATA(FILE_RDATA), .FILE_WE(FILE_WE),
        .FILE_WDATA(FILE_WDATA), .DONE(DONE));
    rfo_mem i_mem (.clk(MCLK), .addr(FILE_ADDR), .re(FILE_RE), .we(FILE_WE), .wdata(FILE_WDATA),
        .rdata(FILE_RDATA));

    always #5 MCLK = ~MCLK;

    // ==========================================
    // bus and instruction drivers, entered just after a rising edge
    task automatic ahb(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        HSEL <= 1'b1;
        HADDR <= {28'h0, a};
        HWRITE <= wr;
        HTRANS <= 2'h2;
        n = 0;
        do begin @(posedge MCLK); n++; end while (HREADYOUT !== 1'b1 && n < 20);
        HTRANS <= 2'h0;
        HSEL <= 1'b0;
        HWDATA <= wd;
        n = 0;
        do begin @(posedge MCLK); n++; end while (HREADYOUT !== 1'b1 && n < 20);
        rd = HRDATA;
    endtask

    task automatic exec(input logic [15:0] w, output int lat);
        int n;
        INSTR <= w;
        INSTR_VALID <= 1'b1;
        n = 0;
        do begin @(posedge MCLK); n++; end while (INSTR_READY !== 1'b1 && n < 20);
        INSTR_VALID <= 1'b0;
        n = 0;
        do begin @(posedge MCLK); n++; end while (DONE !== 1'b1 && n < 8);
        lat = (DONE === 1'b1) ? n : 0;
    endtask

    // {carry, result} worked out independently of the design
    function automatic logic [8:0] rot(input int k, input logic [7:0] v, input logic c);
        case (k)
            0: return {c, v[6:0], v[7]};
            1: return {v[7], v[6:0], c};
            2: return {v[0], c, v[7:1]};
            default: return {c, v[0], v[7:1]};
        endcase
    endfunction

    // ==========================================
    // scenarios
    task automatic t_regs();
        logic [31:0] r;
        ahb(0, `RFO_REG_WORKING_REG, 0, r);
        `RFO_CHK(r, 32'h0)
        ahb(0, `RFO_REG_STAT, 0, r);
        `RFO_CHK(r, 32'h0)
        ahb(1, `RFO_REG_BANK, 32'hFFFFFFF3, r);
        ahb(0, `RFO_REG_BANK, 0, r);
        `RFO_CHK(r, 32'h3)
        $display("register test done");
    endtask

    task automatic t_rot(input int k, input logic d, input logic a, input logic [7:0] f, input logic [7:0] v,
        input logic c);
        logic [8:0] e;
        logic [11:0] fa;
        logic [31:0] r;
        int lat;
        e = rot(k, v, c);
        fa = {a ? 4'h3 : (f[7] ? `RFO_ACC_HI_BANK : `RFO_ACC_LO_BANK), f};
        i_mem.mem[fa] = v;
        ahb(1, `RFO_REG_WORKING_REG, 32'h5A, r);
        ahb(1, `RFO_REG_STAT, {31'h0, c}, r);
        exec({opc[k], d, a, f}, lat);
        `RFO_CHK(lat, 3)
        `RFO_CHK(FILE_ADDR, fa)
        ahb(0, `RFO_REG_WORKING_REG, 0, r);
        `RFO_CHK(r[7:0], d ? 8'h5A : e[7:0])
        `RFO_CHK(i_mem.mem[fa], d ? e[7:0] : v)
        ahb(0, `RFO_REG_STAT, 0, r);
        `RFO_CHK(r[`RFO_STAT_C], e[8])
        `RFO_CHK(r[`RFO_STAT_N], e[7])
        `RFO_CHK(r[`RFO_STAT_Z], e[7:0] == 8'h00)
        ahb(0, `RFO_REG_LAST, 0, r);
        `RFO_CHK(r[7:0], e[7:0])
        $display("rotate test kind %0d done", k);
    endtask

    task automatic t_fill();
        logic [31:0] r;
        int lat;
        i_mem.mem[12'h322] = 8'h5A;
        ahb(1, `RFO_REG_STAT, 32'h15, r);
        ahb(1, `RFO_REG_WORKING_REG, 32'h33, r);
        exec({`RFO_OPC_FILL, 1'b1, 8'h22}, lat);
        `RFO_CHK(lat, 3)
        ahb(0, `RFO_REG_STAT, 0, r);
        `RFO_CHK(r[7:0], 8'h15)
        ahb(0, `RFO_REG_WORKING_REG, 0, r);
        `RFO_CHK(r[7:0], 8'h33)
        `RFO_CHK(i_mem.mem[12'h322], `RFO_FILL_VAL)
        $display("fill test done");
    endtask

    // ==========================================
    // closing and main sequence
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // the whole run needs well under a thousand cycles
    always @(posedge MCLK) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            finish_test();
        end
    end

    initial begin
        repeat (16) @(posedge MCLK);
        RST <= 1'b0;
        @(posedge MCLK);
        t_regs();
        t_rot(1, 1'b0, 1'b0, 8'h10, 8'hE6, 1'b0);
        t_rot(0, 1'b1, 1'b1, 8'h20, 8'hAB, 1'b1);
        t_rot(2, 1'b0, 1'b0, 8'h90, 8'hE6, 1'b0);
        t_rot(3, 1'b1, 1'b0, 8'h05, 8'hD7, 1'b1);
        t_rot(3, 1'b0, 1'b1, 8'h40, 8'h00, 1'b0);
        t_rot(1, 1'b1, 1'b1, 8'hC1, 8'h80, 1'b0);
        t_rot(2, 1'b1, 1'b0, 8'h81, 8'h01, 1'b1);
        t_fill();
        finish_test();
    end
endmodule
